// ==== sfe_ctrl_cfg.svh ====
// constants for the sensor front end control block
`ifndef SFE_CTRL_CFG_SVH
`define SFE_CTRL_CFG_SVH
// ==========================================================
// timing
`define CLK_FREQ_HZ        25000000
`define DEBOUNCE_TIME_US   1000
`define DEBOUNCE_CYCLES    ((`CLK_FREQ_HZ / 1000000) * `DEBOUNCE_TIME_US)
`define DELAY_TICK_US      1000
`define DELAY_TICK_CYCLES  ((`CLK_FREQ_HZ / 1000000) * `DELAY_TICK_US)
`define AC_HALF_PERIOD_US  10
`define AC_HALF_CYCLES     ((`CLK_FREQ_HZ / 1000000) * `AC_HALF_PERIOD_US)
// ==========================================================
// encodings
`define TYPE1_LINEAR       2'b00
`define TYPE1_FOLLOWER     2'b01
`define TYPE1_RESERVED     2'b10
`define TYPE1_AC           2'b11
`define TYPE2_CONDUCTIVE   1'b0
`define TYPE2_FOLLOWER     1'b1
`define SEL_IDLE_REQ       4'h0
`define CNT_W              20
`endif

// ==== sfe_ctrl_pkg.sv ====
// types for the sensor front end control block
package sfe_ctrl_pkg;
  // ==========================================================
  // converter channel selection
  typedef enum logic [1:0] {
    CH_TEMP,
    CH_BATT,
    CH_SENSOR_ONE_INPUT,
    CH_SENSOR_TWO_INPUT
  } channel_t;

  // sensor front end settings
  typedef struct packed {
    logic [1:0] sensor_one_type;
    logic       sensor_two_type;
    logic [4:0] sensor_one_range;
    logic [4:0] sensor_two_range;
    logic       range_preset;
    logic [1:0] limit_check_sensor_select;
    logic       sensor_supply_switch;
  } sfe_cfg_t;

  // conversion request: one bit per channel, plus destination
  typedef struct packed {
    logic [3:0] channels;
    logic       to_reader;
  } conv_req_t;

  // decoded sensor mode
  typedef struct packed {
    logic sensor_one_input_linear;
    logic sensor_one_input_follower;
    logic sensor_one_input_ac;
    logic sensor_one_input_reserved;
    logic sensor_two_input_conductive;
    logic sensor_two_input_follower;
    logic bridge;
  } sensor_mode_t;
endpackage : sfe_ctrl_pkg

// ==== sensor_front_end_control.sv ====
// sensor front end control: converter sequencing, excitation pin, start
`timescale 1ns/1ps
`include "sfe_ctrl_cfg.svh"

module sensor_front_end_control
  import sfe_ctrl_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // settings and logging control
  input  wire sfe_cfg_t          cfg,
  input  wire logic              start_log_cmd,
  input  wire logic              deferred_start_en,
  input  wire logic              delay_mode_timer,
  input  wire logic [15:0]       start_delay_ticks,
  input  wire logic              button_pin,
  input  wire logic              standby,
  input  wire logic              shelf_life_used,
  input  wire logic              shelf_life_expired,
  // conversion requests and converter
  input  wire conv_req_t         conv_req,
  input  wire logic              conv_req_valid,
  output logic                   conv_req_ready,
  input  wire logic [3:0]        sensor_enable,
  output logic                   adc_start,
  output channel_t               adc_channel,
  input  wire logic              adc_done,
  input  wire logic [9:0]        adc_result,
  // results
  output logic                   log_wr,
  output logic                   reader_valid,
  output logic [9:0]             result_q,
  output channel_t               result_channel_q,
  output logic                   limit_sample,
  // analog controls
  output sensor_mode_t           mode_q,
  output logic [4:0]             gain_one_q,
  output logic [4:0]             gain_two_q,
  output logic                   autorange_en_q,
  output logic                   vref_en_q,
  output logic                   exc_out_q,
  output logic                   exc_oe_q,
  output logic                   logging_q
);

  // ==========================================================
  // decoding
  function automatic sensor_mode_t decode_mode(input sfe_cfg_t c);
    sensor_mode_t m;
    m                 = '0;
    m.sensor_one_input_linear     = (c.sensor_one_type == `TYPE1_LINEAR);
    m.sensor_one_input_follower   = (c.sensor_one_type == `TYPE1_FOLLOWER);
    m.sensor_one_input_reserved   = (c.sensor_one_type == `TYPE1_RESERVED);
    m.sensor_one_input_ac         = (c.sensor_one_type == `TYPE1_AC);
    m.sensor_two_input_conductive = (c.sensor_two_type == `TYPE2_CONDUCTIVE);
    m.sensor_two_input_follower   = (c.sensor_two_type == `TYPE2_FOLLOWER);
    m.bridge          = m.sensor_one_input_follower && m.sensor_two_input_follower;
    return m;
  endfunction : decode_mode

  // lowest set channel bit, temp first, sensor_one_input before sensor_two_input
  function automatic logic [1:0] first_channel(input logic [3:0] b);
    logic [1:0] r;
    r = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (b[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction : first_channel

  // ==========================================================
  // settings registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mode_q         <= '0;
      gain_one_q     <= '0;
      gain_two_q     <= '0;
      autorange_en_q <= 1'b1;
      vref_en_q      <= 1'b0;
    end else begin
      mode_q         <= decode_mode(cfg);
      gain_one_q     <= cfg.sensor_one_range;
      gain_two_q     <= cfg.sensor_two_range;
      autorange_en_q <= !cfg.range_preset;
      vref_en_q      <= (cfg.sensor_one_type == `TYPE1_AC);
    end
  end

  // ==========================================================
  // button synchroniser and debouncer
  logic                  btn_s1_q;
  logic                  btn_s2_q;
  logic                  btn_stable_q;
  logic [`CNT_W-1:0]     deb_cnt_q;
  logic                  btn_press;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
    end else begin
      btn_s1_q <= button_pin;
      btn_s2_q <= btn_s1_q;
    end
  end

  // level must hold steady for the debounce time before it is taken
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      deb_cnt_q    <= '0;
      btn_stable_q <= 1'b0;
    end else if (btn_s2_q == btn_stable_q) begin
      deb_cnt_q    <= '0;
    end else if (deb_cnt_q == `CNT_W'(`DEBOUNCE_CYCLES - 1)) begin
      deb_cnt_q    <= '0;
      btn_stable_q <= btn_s2_q;
    end else begin
      deb_cnt_q    <= deb_cnt_q + `CNT_W'(1);
    end
  end

  assign btn_press = btn_s2_q && !btn_stable_q &&
                     (deb_cnt_q == `CNT_W'(`DEBOUNCE_CYCLES - 1));

  // ==========================================================
  // deferred logging start
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_DELAY,
    ST_WAIT_BUTTON,
    ST_LOGGING
  } start_state_t;

  start_state_t          start_q;
  logic [15:0]           delay_left_q;
  logic [`CNT_W-1:0]     tick_cnt_q;
  logic                  tick;

  assign tick = (tick_cnt_q == `CNT_W'(`DELAY_TICK_CYCLES - 1));

  // tick prescaler for the programmed delay
  always_ff @(posedge sys_clk) begin
    if (!resetn || start_q != ST_WAIT_DELAY) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + `CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      start_q      <= ST_IDLE;
      delay_left_q <= '0;
    end else begin
      case (start_q)
        ST_IDLE: begin
          if (start_log_cmd) begin
            delay_left_q <= start_delay_ticks;
            if (deferred_start_en) begin
              start_q <= ST_WAIT_BUTTON;
            end else if (delay_mode_timer) begin
              start_q <= ST_WAIT_DELAY;
            end else begin
              start_q <= ST_LOGGING;
            end
          end
        end
        ST_WAIT_DELAY: begin
          if (delay_left_q == 16'h0000) begin
            start_q <= ST_LOGGING;
          end else if (tick) begin
            delay_left_q <= delay_left_q - 16'h0001;
          end
        end
        ST_WAIT_BUTTON: begin
          if (btn_press) begin
            start_q <= ST_LOGGING;
          end
        end
        ST_LOGGING: begin
          start_q <= ST_LOGGING;
        end
        default: begin
          start_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign logging_q = (start_q == ST_LOGGING);

  // ==========================================================
  // conversion sequencer, one channel at a time
  typedef enum logic [1:0] {
    CV_IDLE,
    CV_ISSUE,
    CV_BUSY
  } conv_state_t;

  conv_state_t           conv_q;
  logic [3:0]            pending_q;
  logic                  to_reader_q;
  channel_t              chan_q;

  assign conv_req_ready = (conv_q == CV_IDLE);
  assign adc_start      = (conv_q == CV_ISSUE);
  assign adc_channel    = chan_q;

  // pending bits are drained lowest first, so sensor_one_input precedes sensor_two_input
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      conv_q      <= CV_IDLE;
      pending_q   <= `SEL_IDLE_REQ;
      to_reader_q <= 1'b0;
      chan_q      <= CH_TEMP;
    end else begin
      case (conv_q)
        CV_IDLE: begin
          if (conv_req_valid && conv_req.channels != 4'h0) begin
            pending_q   <= conv_req.channels;
            to_reader_q <= conv_req.to_reader;
            chan_q      <= channel_t'(first_channel(conv_req.channels));
            conv_q      <= CV_ISSUE;
          end
        end
        CV_ISSUE: begin
          conv_q <= CV_BUSY;
        end
        CV_BUSY: begin
          if (adc_done) begin
            pending_q[chan_q] <= 1'b0;
            if ((pending_q & ~(4'h1 << chan_q)) == 4'h0) begin
              conv_q <= CV_IDLE;
            end else begin
              chan_q <= channel_t'(first_channel(
                          pending_q & ~(4'h1 << chan_q)));
              conv_q <= CV_ISSUE;
            end
          end
        end
        default: begin
          conv_q <= CV_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // result capture and routing
  logic [1:0]            rank;
  logic                  done_now;

  assign done_now = (conv_q == CV_BUSY) && adc_done;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      result_q         <= '0;
      result_channel_q <= CH_TEMP;
      log_wr           <= 1'b0;
      reader_valid     <= 1'b0;
      limit_sample     <= 1'b0;
    end else begin
      log_wr       <= done_now && !to_reader_q;
      reader_valid <= done_now && to_reader_q;
      limit_sample <= done_now && !to_reader_q &&
                      sensor_enable[chan_q] &&
                      (rank == cfg.limit_check_sensor_select);
      if (done_now) begin
        result_q         <= adc_result;
        result_channel_q <= chan_q;
      end
    end
  end

  // position of the current channel among the enabled sensors
  always_comb begin
    rank = 2'b00;
    for (int i = 0; i < 4; i++) begin
      if (i < int'(chan_q) && sensor_enable[i]) begin
        rank = rank + 2'b01;
      end
    end
  end

  // ==========================================================
  // excitation pin control
  logic [`CNT_W-1:0]     ac_cnt_q;
  logic                  ac_phase_q;
  logic                  ext_conv;

  assign ext_conv = (conv_q != CV_IDLE) &&
                    (chan_q == CH_SENSOR_ONE_INPUT || chan_q == CH_SENSOR_TWO_INPUT);

  // square wave stimulus, runs only while an external channel converts
  always_ff @(posedge sys_clk) begin
    if (!resetn || !ext_conv) begin
      ac_cnt_q   <= '0;
      ac_phase_q <= 1'b0;
    end else if (ac_cnt_q == `CNT_W'(`AC_HALF_CYCLES - 1)) begin
      ac_cnt_q   <= '0;
      ac_phase_q <= !ac_phase_q;
    end else begin
      ac_cnt_q   <= ac_cnt_q + `CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      exc_out_q <= 1'b0;
      exc_oe_q  <= 1'b0;
    end else if (cfg.sensor_one_type == `TYPE1_AC) begin
      exc_out_q <= ac_phase_q;
      exc_oe_q  <= ext_conv;
    end else if (cfg.sensor_supply_switch) begin
      exc_out_q <= 1'b1;
      exc_oe_q  <= (conv_q != CV_IDLE) && !standby;
    end else if (shelf_life_used) begin
      exc_out_q <= shelf_life_expired;
      exc_oe_q  <= 1'b1;
    end else begin
      exc_out_q <= 1'b0;
      exc_oe_q  <= 1'b0;
    end
  end

endmodule : sensor_front_end_control

// ==== sfe_ctrl_props.sv ====
// checker for the sensor front end control block
`timescale 1ns/1ps
module sfe_ctrl_props
  import sfe_ctrl_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         resetn,
  input wire sfe_cfg_t     cfg,
  input wire logic         shelf_life_used,
  input wire logic         shelf_life_expired,
  input wire logic         standby,
  input wire conv_req_t    conv_req,
  input wire logic         conv_req_valid,
  input wire logic         conv_req_ready,
  input wire logic         adc_start,
  input wire logic         adc_done,
  input wire logic [9:0]   adc_result,
  input wire logic         log_wr,
  input wire logic         reader_valid,
  input wire logic [9:0]   result_q,
  input wire sensor_mode_t mode_q,
  input wire logic [4:0]   gain_one_q,
  input wire logic         autorange_en_q,
  input wire logic         vref_en_q,
  input wire logic         exc_out_q,
  input wire logic         exc_oe_q
);
  logic busy_q;
  // ==========================================================
  // converter occupancy
  always_ff @(posedge sys_clk) begin
    if (!resetn) busy_q <= 1'b0;
    else if (adc_start) busy_q <= 1'b1;
    else if (adc_done) busy_q <= 1'b0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence take_s;
    conv_req_valid && conv_req_ready && (|conv_req.channels);
  endsequence
  sequence result_s;
    (log_wr ^ reader_valid) && result_q == $past(adc_result);
  endsequence
  // ==========================================================
  // properties
  take_start_a: assert property (take_s |=> adc_start)
    else $error("no converter start after take");
  no_overlap_a: assert property (adc_start |-> !busy_q)
    else $error("converter started while busy");
  result_out_a: assert property (adc_done && busy_q |=> result_s)
    else $error("result not delivered after done");
  gain_copy_a: assert property ($past(resetn) |->
    gain_one_q == $past(cfg.sensor_one_range)) else $error("bad gain");
  type_decode_a: assert property ($past(resetn) |->
    mode_q.sensor_one_input_ac == ($past(cfg.sensor_one_type) == 2'b11) &&
    mode_q.sensor_one_input_linear == ($past(cfg.sensor_one_type) == 2'b00) &&
    mode_q.sensor_two_input_follower == $past(cfg.sensor_two_type))
    else $error("bad sensor type decode");
  preset_off_a: assert property ($past(resetn) |->
    autorange_en_q == !$past(cfg.range_preset)) else $error("bad autorange");
  ac_vref_a: assert property ($past(resetn) |->
    vref_en_q == ($past(cfg.sensor_one_type) == 2'b11))
    else $error("bad reference enable");
  exc_off_a: assert property ($past(resetn) &&
    $past(cfg.sensor_one_type) == 2'b00 && !$past(cfg.sensor_supply_switch)
    && !$past(shelf_life_used) |-> !exc_oe_q) else $error("pin driven");
  exc_standby_a: assert property ($past(resetn) && $past(standby) &&
    $past(cfg.sensor_one_type) == 2'b00 && $past(cfg.sensor_supply_switch)
    |-> !exc_oe_q) else $error("pin driven in standby");
  alarm_out_a: assert property ($past(resetn) &&
    $past(cfg.sensor_one_type) == 2'b00 && !$past(cfg.sensor_supply_switch)
    && $past(shelf_life_used && shelf_life_expired) |-> exc_oe_q && exc_out_q)
    else $error("alarm not driven");
endmodule : sfe_ctrl_props

bind sensor_front_end_control sfe_ctrl_props sfe_ctrl_props_inst (
  .sys_clk, .resetn, .cfg, .shelf_life_used, .shelf_life_expired, .standby,
  .conv_req, .conv_req_valid, .conv_req_ready, .adc_start, .adc_done,
  .adc_result, .log_wr, .reader_valid, .result_q, .mode_q, .gain_one_q,
  .autorange_en_q, .vref_en_q, .exc_out_q, .exc_oe_q);

// ==== adc_model.sv ====
// converter model answering each start after a set latency
`timescale 1ns/1ps
module adc_model (
  input  wire logic       sys_clk,
  input  wire logic       adc_start,
  input  wire logic [9:0] lat,
  output logic            adc_done,
  output logic [9:0]      adc_result
);
  int seed = 32'h0000_1234;
  // ==========================================================
  // result valid only with done, inverted afterwards
  initial begin
    adc_done = 1'b0;
    adc_result = 10'h000;
    forever begin
      @(posedge sys_clk);
      if (adc_start === 1'b1) begin
        repeat (lat) @(posedge sys_clk);
        #1;
        adc_done = 1'b1;
        adc_result = 10'($random(seed));
        @(posedge sys_clk);
        #1;
        adc_done = 1'b0;
        adc_result = ~adc_result;
      end
    end
  end
endmodule : adc_model

// ==== tb_sensor_front_end_control.sv ====
// testbench for the sensor front end control block
`timescale 1ns/1ps
module tb_sensor_front_end_control
  import sfe_ctrl_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, start_log_cmd, deferred_start_en;
  logic delay_mode_timer, button_pin, standby, shelf_life_used;
  logic shelf_life_expired, conv_req_valid, conv_req_ready, adc_start;
  logic adc_done, log_wr, reader_valid, limit_sample, autorange_en_q;
  logic vref_en_q, exc_out_q, exc_oe_q, logging_q;
  logic [15:0] start_delay_ticks;
  logic [3:0]  sensor_enable;
  logic [9:0]  adc_result, result_q, lat;
  logic [4:0]  gain_one_q, gain_two_q;
  logic [31:0] r;
  sfe_cfg_t     cfg;
  conv_req_t    conv_req;
  channel_t     adc_channel, result_channel_q;
  sensor_mode_t mode_q;
  int error_cnt = 0, n_tests = 0, k, seed = 32'ha8ec_71ab;
  logic [1:0] chq[$];
  logic       rdq[$];
  logic [9:0] resq[$];
  logic       limq[$];

  // ==========================================================
  // expectations: limit pick is the sel-th enabled sensor, lowest first
  function automatic logic exp_limit(input logic [1:0] ch, input logic rd,
                                     input logic [3:0] en,
                                     input logic [1:0] sel);
    logic [1:0] n;
    n = 2'b00;
    for (int i = 0; i < 4; i++) if (i < ch && en[i]) n = n + 2'b01;
    return !rd && en[ch] && (n == sel);
  endfunction : exp_limit
  // sensor type table, bridge is type one 01 with type two 1
  function automatic sensor_mode_t exp_mode(input sfe_cfg_t c);
    exp_mode = '{c.sensor_one_type == 2'b00, c.sensor_one_type == 2'b01,
      c.sensor_one_type == 2'b11, c.sensor_one_type == 2'b10,
      !c.sensor_two_type, c.sensor_two_type,
      c.sensor_one_type == 2'b01 && c.sensor_two_type};
  endfunction : exp_mode

  sensor_front_end_control sensor_front_end_control_inst (.sys_clk, .resetn,
    .cfg, .start_log_cmd, .deferred_start_en, .delay_mode_timer,
    .start_delay_ticks, .button_pin, .standby, .shelf_life_used,
    .shelf_life_expired, .conv_req, .conv_req_valid, .conv_req_ready,
    .sensor_enable, .adc_start, .adc_channel, .adc_done, .adc_result, .log_wr,
    .reader_valid, .result_q, .result_channel_q, .limit_sample, .mode_q,
    .gain_one_q, .gain_two_q, .autorange_en_q, .vref_en_q, .exc_out_q,
    .exc_oe_q, .logging_q);
  adc_model adc_model_inst (.sys_clk, .adc_start, .lat, .adc_done,
    .adc_result);

  // ==========================================================
  // clock, helpers
  always #20 sys_clk = ~sys_clk;
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task conclude;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task do_reset;
    resetn = 1'b0;
    cyc(3);
    chk({conv_req_ready, autorange_en_q, logging_q}, 16'h0006);
    resetn = 1'b1;
  endtask : do_reset
  task go;
    start_log_cmd = 1'b1;
    cyc(1);
    start_log_cmd = 1'b0;
  endtask : go
  // queue expected channels lowest first, hold valid for one edge;
  // an edge passes first so valid never rises in the step it fell
  task req(input logic [3:0] ch, input logic rd);
    cyc(1);
    k = 0;
    while (conv_req_ready !== 1'b1 && k < 5000) begin
      cyc(1);
      k++;
    end
    chk(conv_req_ready, 16'h0001);
    conv_req = '{ch, rd};
    conv_req_valid = 1'b1;
    for (int i = 0; i < 4; i++) if (ch[i]) begin
      chq.push_back(2'(i));
      rdq.push_back(rd);
    end
    cyc(1);
    conv_req_valid = 1'b0;
  endtask : req

  // ==========================================================
  // result monitor
  always @(posedge sys_clk) begin
    #2;
    if (adc_done === 1'b1) begin
      resq.push_back(adc_result);
      limq.push_back(exp_limit(chq[0], rdq[0], sensor_enable,
                               cfg.limit_check_sensor_select));
      chk(adc_channel, chq[0]);
    end
    if (log_wr === 1'b1 || reader_valid === 1'b1) begin
      chk(limit_sample, limq.pop_front());
      chk(result_q, resq.pop_front());
      chk(result_channel_q, chq.pop_front());
      chk(reader_valid, rdq.pop_front());
    end
  end
  // watchdog
  initial begin
    #(40 * 95000);
    error_cnt++;
    conclude;
  end

  // ==========================================================
  // main sequence
  initial begin
    cfg = '0;
    conv_req = '0;
    {conv_req_valid, start_log_cmd, deferred_start_en} = 3'b000;
    {delay_mode_timer, button_pin, standby} = 3'b000;
    {shelf_life_used, shelf_life_expired} = 2'b00;
    start_delay_ticks = 16'h0001;
    sensor_enable = 4'hf;
    lat = 10'h002;
    do_reset;
    go;
    cyc(3);
    chk(logging_q, 16'h0001);
    do_reset;
    delay_mode_timer = 1'b1;
    go;
    cyc(100);
    chk(logging_q, 16'h0000);
    k = 0;
    while (logging_q !== 1'b1 && k < 30000) begin
      cyc(1);
      k++;
    end
    chk(logging_q, 16'h0001);
    do_reset;
    deferred_start_en = 1'b1;
    go;
    button_pin = 1'b1;
    cyc(4);
    button_pin = 1'b0;
    cyc(26000);
    chk(logging_q, 16'h0000);
    button_pin = 1'b1;
    k = 0;
    while (logging_q !== 1'b1 && k < 30000) begin
      cyc(1);
      k++;
    end
    chk(logging_q, 16'h0001);
    button_pin = 1'b0;
    do_reset;
    conv_req = '{4'b0000, 1'b1};
    conv_req_valid = 1'b1;
    cyc(1);
    chk({adc_start, conv_req_ready}, 16'h0001);
    conv_req_valid = 1'b0;
    req(4'b1100, 1'b0);
    cfg.sensor_one_type = 2'b11;
    lat = 10'h190;
    req(4'b0100, 1'b1);
    cyc(300);
    chk({exc_oe_q, exc_out_q}, 16'h0003);
    cyc(150);
    chk(exc_oe_q, 16'h0000);
    for (int n = 0; n < 150; n++) begin
      r = $random(seed);
      cfg = r[16:0];
      {shelf_life_expired, shelf_life_used, standby} = r[19:17];
      lat = 10'(r[22:20]) + 10'h001;
      sensor_enable = r[31:28];
      req(r[26:23], r[27]);
      chk(gain_two_q, cfg.sensor_two_range);
      chk(16'(mode_q), 16'(exp_mode(cfg)));
    end
    k = 0;
    while ((chq.size() != 0 || conv_req_ready !== 1'b1) && k < 5000) begin
      cyc(1);
      k++;
    end
    chk(16'(chq.size()), 16'h0000);
    conclude;
  end
endmodule : tb_sensor_front_end_control
